// File: rtl/cpurs_pkg.sv
// Package: register set constants, memory map and carrier types
package cpurs_pkg;
   localparam int ADDR_W = 20;
   localparam int REG_IDX_W = 5;
   localparam logic [19:0] SPACE_LO = 20'h00000;
   localparam logic [19:0] SPACE_HI = 20'hfffff;
   localparam logic [19:0] PERIPH_LO = 20'h00000;
   localparam logic [19:0] PERIPH_HI = 20'h003ff;
   localparam logic [19:0] RAM_LO = 20'h00400;
   localparam logic [19:0] RAM_HI = 20'h017ff;
   localparam logic [19:0] ROM_LO = 20'he0000;
   localparam logic [19:0] ROM_HI = 20'hfffff;
   localparam logic [19:0] SPVEC_LO = 20'hffe00;
   localparam logic [19:0] SPVEC_HI = 20'hfffdb;
   localparam logic [19:0] FIXVEC_BASE = 20'hfffdc;
   // Register port indices
   localparam logic [4:0] IDX_DATA0 = 5'h00;
   localparam logic [4:0] IDX_DATA1 = 5'h01;
   localparam logic [4:0] IDX_DATA2 = 5'h02;
   localparam logic [4:0] IDX_DATA3 = 5'h03;
   localparam logic [4:0] IDX_ADDRLO = 5'h04;
   localparam logic [4:0] IDX_ADDRHI = 5'h05;
   localparam logic [4:0] IDX_FRAME = 5'h06;
   localparam logic [4:0] IDX_VTB = 5'h07;
   localparam logic [4:0] IDX_IP = 5'h08;
   localparam logic [4:0] IDX_USP = 5'h09;
   localparam logic [4:0] IDX_ISP = 5'h0a;
   localparam logic [4:0] IDX_SB = 5'h0b;
   localparam logic [4:0] IDX_FLAGS = 5'h0c;
   localparam logic [4:0] IDX_SP = 5'h0d;
   localparam logic [4:0] IDX_D0LO = 5'h0e;
   localparam logic [4:0] IDX_D0HI = 5'h0f;
   localparam logic [4:0] IDX_D1LO = 5'h10;
   localparam logic [4:0] IDX_D1HI = 5'h11;
   localparam logic [4:0] IDX_PAIRLO_L = 5'h12;
   localparam logic [4:0] IDX_PAIRLO_H = 5'h13;
   localparam logic [4:0] IDX_PAIRHI_L = 5'h14;
   localparam logic [4:0] IDX_PAIRHI_H = 5'h15;
   localparam logic [4:0] IDX_ADDRW_L = 5'h16;
   localparam logic [4:0] IDX_ADDRW_H = 5'h17;
   localparam logic [4:0] IDX_DECODE = 5'h18;
   // Flag bits: bank select and stack select
   localparam int FLG_BANK = 0;
   localparam int FLG_STACK = 1;
   localparam logic [1:0] FLAGS_RST = 2'h0;
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [19:0] REG20_RST = 20'h00000;
   localparam logic [31:0] RD_RST = 32'h00000000;

   typedef enum logic [2:0]
   {
      REGION_PERIPH,
      REGION_RAM,
      REGION_ROM,
      REGION_SPVEC,
      REGION_FIXVEC,
      REGION_NONE
   } cpurs_region_t;

   typedef struct packed
   {
      logic [15:0] data0;
      logic [15:0] data1;
      logic [15:0] data2;
      logic [15:0] data3;
      logic [15:0] addrLo;
      logic [15:0] addrHi;
      logic [15:0] frame;
   } cpurs_bank_t;

   typedef struct packed
   {
      logic [4:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } cpurs_bus_t;

   typedef struct packed
   {
      logic isPeriph;
      logic isRam;
      logic isRom;
      logic isSpVec;
      logic isFixVec;
   } cpurs_decode_t;
endpackage : cpurs_pkg

// File: rtl/cpurs_register_set.sv
// Register set: two banks, shared registers, address decoder, oscillator select
`timescale 1ns/1ps
`default_nettype none
module cpurs_register_set
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire cpurs_pkg::cpurs_bus_t bus,
   output var logic [31:0] rdata,
   input wire logic irqAccept,
   input wire logic [19:0] probeAddr,
   output var cpurs_pkg::cpurs_decode_t probeDecode,
   input wire logic oscSelect,
   output var logic mainOscSel,
   output var logic [15:0] activeStackPtr,
   output var logic bankSel
);
   import cpurs_pkg::*;

   typedef struct packed
   {
      cpurs_bank_t bank0;
      cpurs_bank_t bank1;
      logic [19:0] vtb;
      logic [19:0] ip;
      logic [15:0] user_stack_ptr;
      logic [15:0] irq_stack_ptr;
      logic [15:0] sb;
      logic [1:0] flags;
      logic [31:0] rdata;
      logic mainOsc;
      logic irqPrev;
      cpurs_decode_t dec;
      logic [15:0] activeSp;
   } cpurs_state_t;

   cpurs_state_t state_reg;
   cpurs_state_t state_next;
   cpurs_bank_t cur;
   cpurs_bank_t wb;
   logic [31:0] rv;
   logic irqEdge;
   logic oscSync;
   logic irqSync;

   // Both pins come from outside the clock domain
   cpurs_sync2
   #(
      .W(1)
   )
   u_cpurs_sync2_osc
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .pinIn(oscSelect),
      .pinSync(oscSync)
   );

   cpurs_sync2
   #(
      .W(1)
   )
   u_cpurs_sync2_irq
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .pinIn(irqAccept),
      .pinSync(irqSync)
   );

   function automatic cpurs_decode_t decodeAddr(input logic [19:0] a);
      cpurs_decode_t d;
      d = '0;
      if (a <= PERIPH_HI)
      begin
         d.isPeriph = 1'b1;
      end
      else if (a >= RAM_LO && a <= RAM_HI)
      begin
         d.isRam = 1'b1;
      end
      else if (a >= ROM_LO)
      begin
         d.isRom = 1'b1;
         if (a >= FIXVEC_BASE)
         begin
            d.isFixVec = 1'b1;
         end
         else if (a >= SPVEC_LO && a <= SPVEC_HI)
         begin
            d.isSpVec = 1'b1;
         end
      end
      return d;
   endfunction : decodeAddr

   always_comb
   begin
      state_next = state_reg;
      irqEdge = irqSync && !state_reg.irqPrev;
      // Active bank chosen by flag; other bank untouched
      cur = state_reg.flags[FLG_BANK] ? state_reg.bank1 : state_reg.bank0;
      wb = cur;
      rv = '0;
      // Read mux
      if (bus.addr == IDX_DATA0)
      begin
         rv = {16'h0000, cur.data0};
      end
      else if (bus.addr == IDX_DATA1)
      begin
         rv = {16'h0000, cur.data1};
      end
      else if (bus.addr == IDX_DATA2)
      begin
         rv = {16'h0000, cur.data2};
      end
      else if (bus.addr == IDX_DATA3)
      begin
         rv = {16'h0000, cur.data3};
      end
      else if (bus.addr == IDX_ADDRLO)
      begin
         rv = {16'h0000, cur.addrLo};
      end
      else if (bus.addr == IDX_ADDRHI)
      begin
         rv = {16'h0000, cur.addrHi};
      end
      else if (bus.addr == IDX_FRAME)
      begin
         rv = {16'h0000, cur.frame};
      end
      else if (bus.addr == IDX_VTB)
      begin
         rv = {12'h000, state_reg.vtb};
      end
      else if (bus.addr == IDX_IP)
      begin
         rv = {12'h000, state_reg.ip};
      end
      else if (bus.addr == IDX_USP)
      begin
         rv = {16'h0000, state_reg.user_stack_ptr};
      end
      else if (bus.addr == IDX_ISP)
      begin
         rv = {16'h0000, state_reg.irq_stack_ptr};
      end
      else if (bus.addr == IDX_SB)
      begin
         rv = {16'h0000, state_reg.sb};
      end
      else if (bus.addr == IDX_FLAGS)
      begin
         rv = {30'h0, state_reg.flags};
      end
      else if (bus.addr == IDX_SP)
      begin
         rv = {16'h0000, state_reg.activeSp};
      end
      else if (bus.addr == IDX_D0LO)
      begin
         rv = {24'h000000, cur.data0[7:0]};
      end
      else if (bus.addr == IDX_D0HI)
      begin
         rv = {24'h000000, cur.data0[15:8]};
      end
      else if (bus.addr == IDX_D1LO)
      begin
         rv = {24'h000000, cur.data1[7:0]};
      end
      else if (bus.addr == IDX_D1HI)
      begin
         rv = {24'h000000, cur.data1[15:8]};
      end
      else if (bus.addr == IDX_PAIRLO_L || bus.addr == IDX_PAIRLO_H)
      begin
         rv = {cur.data2, cur.data0};
      end
      else if (bus.addr == IDX_PAIRHI_L || bus.addr == IDX_PAIRHI_H)
      begin
         rv = {cur.data3, cur.data1};
      end
      else if (bus.addr == IDX_ADDRW_L || bus.addr == IDX_ADDRW_H)
      begin
         rv = {cur.addrHi, cur.addrLo};
      end
      else if (bus.addr == IDX_DECODE)
      begin
         rv = {27'h0000000, state_reg.dec};
      end
      if (bus.rd)
      begin
         state_next.rdata = rv;
      end
      else
      begin
         state_next.rdata = RD_RST;
      end
      // Writes
      if (bus.wr)
      begin
         if (bus.addr == IDX_DATA0)
         begin
            wb.data0 = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_DATA1)
         begin
            wb.data1 = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_DATA2)
         begin
            wb.data2 = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_DATA3)
         begin
            wb.data3 = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_ADDRLO)
         begin
            wb.addrLo = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_ADDRHI)
         begin
            wb.addrHi = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_FRAME)
         begin
            wb.frame = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_VTB)
         begin
            state_next.vtb = bus.wdata[19:0];
         end
         else if (bus.addr == IDX_IP)
         begin
            state_next.ip = bus.wdata[19:0];
         end
         else if (bus.addr == IDX_USP)
         begin
            state_next.user_stack_ptr = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_ISP)
         begin
            state_next.irq_stack_ptr = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_SB)
         begin
            state_next.sb = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_FLAGS)
         begin
            state_next.flags = bus.wdata[1:0];
         end
         else if (bus.addr == IDX_SP)
         begin
            // Writes the stack pointer currently in use
            if (state_reg.flags[FLG_STACK])
            begin
               state_next.user_stack_ptr = bus.wdata[15:0];
            end
            else
            begin
               state_next.irq_stack_ptr = bus.wdata[15:0];
            end
         end
         else if (bus.addr == IDX_D0LO)
         begin
            wb.data0[7:0] = bus.wdata[7:0];
         end
         else if (bus.addr == IDX_D0HI)
         begin
            wb.data0[15:8] = bus.wdata[7:0];
         end
         else if (bus.addr == IDX_D1LO)
         begin
            wb.data1[7:0] = bus.wdata[7:0];
         end
         else if (bus.addr == IDX_D1HI)
         begin
            wb.data1[15:8] = bus.wdata[7:0];
         end
         else if (bus.addr == IDX_PAIRLO_L || bus.addr == IDX_PAIRLO_H)
         begin
            wb.data2 = bus.wdata[31:16];
            wb.data0 = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_PAIRHI_L || bus.addr == IDX_PAIRHI_H)
         begin
            wb.data3 = bus.wdata[31:16];
            wb.data1 = bus.wdata[15:0];
         end
         else if (bus.addr == IDX_ADDRW_L || bus.addr == IDX_ADDRW_H)
         begin
            wb.addrHi = bus.wdata[31:16];
            wb.addrLo = bus.wdata[15:0];
         end
      end
      // Only the selected bank is written back
      if (state_reg.flags[FLG_BANK])
      begin
         state_next.bank1 = wb;
      end
      else
      begin
         state_next.bank0 = wb;
      end
      // Interrupt acceptance wins over a same-cycle flag write
      if (irqEdge)
      begin
         state_next.flags[FLG_STACK] = 1'b0;
      end
      state_next.activeSp = state_next.flags[FLG_STACK] ?
         state_next.user_stack_ptr : state_next.irq_stack_ptr;
      // Oscillator select pin, synchronised
      state_next.mainOsc = oscSync;
      state_next.irqPrev = irqSync;
      state_next.dec = decodeAddr(probeAddr);
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign probeDecode = state_reg.dec;
   assign mainOscSel = state_reg.mainOsc;
   assign activeStackPtr = state_reg.activeSp;
   assign bankSel = state_reg.flags[FLG_BANK];
endmodule : cpurs_register_set

// Two-stage synchroniser for pins from outside the clock domain
module cpurs_sync2
#(
   parameter int W = 1
)
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [W-1:0] pinIn,
   output var logic [W-1:0] pinSync
);
   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } cpurs_sync_t;

   cpurs_sync_t state_reg;
   cpurs_sync_t state_next;

   // First stage may go metastable, so only the second is read
   always_comb
   begin
      state_next.meta = pinIn;
      state_next.sync = state_reg.meta;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign pinSync = state_reg.sync;
endmodule : cpurs_sync2
`default_nettype wire

// File: test/cpurs_assertions.sv
// Port-level assertions for the register set
`timescale 1ns/1ps
`default_nettype none
module cpurs_assertions
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire cpurs_pkg::cpurs_bus_t bus,
   input wire logic [19:0] probeAddr,
   input wire cpurs_pkg::cpurs_decode_t probeDecode,
   input wire logic oscSelect,
   input wire logic mainOscSel,
   input wire logic bankSel
);
   import cpurs_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_bank_write: assert property (
      bus.wr && bus.addr == IDX_FLAGS |=> bankSel == $past(bus.wdata[0]))
      else $error("bank flag not taken from flags write");
   a_bank_hold: assert property (
      !(bus.wr && bus.addr == IDX_FLAGS) |=> $stable(bankSel))
      else $error("bank flag moved without a flags write");
   // Three sync edges, so five quiet samples are always enough
   a_osc_follow: assert property (
      $stable(oscSelect) [*5] |-> mainOscSel == oscSelect)
      else $error("oscillator select does not follow pin");
   a_decode_rom: assert property (
      probeAddr >= ROM_LO |=> probeDecode.isRom && !probeDecode.isRam)
      else $error("rom decode wrong");
   a_decode_ram: assert property (
      probeAddr inside {[RAM_LO:RAM_HI]} |=> probeDecode == 5'h08)
      else $error("ram decode wrong");
   a_decode_periph: assert property (
      probeAddr <= PERIPH_HI |=> probeDecode == 5'h10)
      else $error("peripheral decode wrong");
   a_decode_spvec: assert property (
      probeAddr inside {[SPVEC_LO:SPVEC_HI]} |=>
      probeDecode.isSpVec && !probeDecode.isFixVec)
      else $error("special page vector decode wrong");
   a_decode_fixvec: assert property (
      probeAddr >= FIXVEC_BASE |=>
      probeDecode.isFixVec && !probeDecode.isSpVec)
      else $error("fixed vector decode wrong");
   a_decode_gap: assert property (
      probeAddr inside {[20'h01800:20'hdffff]} |=> probeDecode == 5'h00)
      else $error("unmapped address decoded");
endmodule : cpurs_assertions
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the register set
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cpurs_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   cpurs_bus_t bus = '0;
   logic [31:0] rdata;
   logic irqAccept = 1'b0;
   logic [19:0] probeAddr = 20'h00000;
   cpurs_decode_t probeDecode;
   logic oscSelect = 1'b0;
   logic mainOscSel;
   logic [15:0] activeStackPtr;
   logic bankSel;
   int err_total = 0;
   int tests_run = 0;
   logic [31:0] expQ[$];
   logic rdPend = 1'b0;
   logic [31:0] seed = 32'h10;
   logic [31:0] keep[12];
   logic [31:0] wide;
   logic [19:0] edges[12] = '{20'h0, 20'h3ff, 20'h400, 20'h17ff, 20'h1800,
      20'hdffff, 20'he0000, 20'hffdff, 20'hffe00, 20'hfffdb, 20'hfffdc,
      20'hfffff};

   cpurs_register_set u_cpurs_register_set
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .bus(bus),
      .rdata(rdata),
      .irqAccept(irqAccept),
      .probeAddr(probeAddr),
      .probeDecode(probeDecode),
      .oscSelect(oscSelect),
      .mainOscSel(mainOscSel),
      .activeStackPtr(activeStackPtr),
      .bankSel(bankSel)
   );

   initial forever #25 clk_sys = ~clk_sys;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Shared registers 7 and 8 are 20 bits, the rest 16
   function automatic logic [31:0] msk(int i, logic [31:0] v);
      return (i == 7 || i == 8) ? {12'h0, v[19:0]} : {16'h0, v[15:0]};
   endfunction : msk

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wrReg(logic [4:0] a, logic [31:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      bus.rd <= 1'b0;
      @(posedge clk_sys);
   endtask : wrReg

   task automatic rdReg(logic [4:0] a, logic [31:0] e);
      expQ.push_back(e);
      bus.addr <= a;
      bus.wr <= 1'b0;
      bus.rd <= 1'b1;
      @(posedge clk_sys);
   endtask : rdReg

   task automatic idle(int n);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask : idle

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_sys)
   begin
      if (rdPend)
         chk("rdata", expQ.pop_front(), rdata);
      rdPend <= bus.rd;
   end

   initial
   begin
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 13; i++)
         rdReg(i[4:0], 32'h0);
      wrReg(5'h19, xs());
      rdReg(5'h19, 32'h0);
      idle(2);
      $display("reset values done");
      for (int i = 0; i < 12; i++)
      begin
         keep[i] = xs();
         wrReg(i[4:0], keep[i]);
         keep[i] = msk(i, keep[i]);
         rdReg(i[4:0], keep[i]);
      end
      wrReg(IDX_FLAGS, 32'h1);
      for (int i = 0; i < 12; i++)
         rdReg(i[4:0], i < 7 ? 32'h0 : keep[i]);
      for (int i = 0; i < 7; i++)
         wrReg(i[4:0], xs());
      wrReg(IDX_FLAGS, 32'h0);
      for (int i = 0; i < 7; i++)
         rdReg(i[4:0], keep[i]);
      idle(2);
      $display("banks done");
      wrReg(IDX_D0HI, 32'hab);
      keep[0][15:8] = 8'hab;
      rdReg(IDX_DATA0, keep[0]);
      rdReg(IDX_D0LO, {24'h0, keep[0][7:0]});
      rdReg(IDX_D1HI, {24'h0, keep[1][15:8]});
      rdReg(IDX_PAIRLO_L, {keep[2][15:0], keep[0][15:0]});
      rdReg(IDX_PAIRLO_H, {keep[2][15:0], keep[0][15:0]});
      rdReg(IDX_PAIRHI_H, {keep[3][15:0], keep[1][15:0]});
      rdReg(IDX_ADDRW_H, {keep[5][15:0], keep[4][15:0]});
      rdReg(IDX_DECODE, 32'h10);
      wide = xs();
      wrReg(IDX_PAIRHI_L, wide);
      rdReg(IDX_DATA3, {16'h0, wide[31:16]});
      wrReg(IDX_D1LO, 32'h5a);
      rdReg(IDX_DATA1, {16'h0, wide[15:8], 8'h5a});
      wide = xs();
      wrReg(IDX_ADDRW_L, wide);
      rdReg(IDX_ADDRLO, {16'h0, wide[15:0]});
      rdReg(IDX_ADDRHI, {16'h0, wide[31:16]});
      idle(2);
      $display("aliases done");
      wrReg(IDX_FLAGS, 32'h3);
      rdReg(IDX_SP, keep[9]);
      idle(1);
      @(negedge clk_sys);
      chk("activeStackPtr", keep[9], {16'h0, activeStackPtr});
      @(posedge clk_sys);
      irqAccept <= 1'b1;
      idle(5);
      irqAccept <= 1'b0;
      rdReg(IDX_FLAGS, 32'h1);
      rdReg(IDX_SP, keep[10]);
      keep[10] = msk(10, xs());
      wrReg(IDX_SP, keep[10]);
      rdReg(IDX_ISP, keep[10]);
      wrReg(IDX_FLAGS, 32'h0);
      idle(2);
      $display("stack select done");
      oscSelect <= 1'b1;
      idle(6);
      @(negedge clk_sys);
      chk("mainOscSel", 32'h1, {31'h0, mainOscSel});
      @(posedge clk_sys);
      oscSelect <= 1'b0;
      for (int i = 0; i < 48; i++)
      begin
         wide = xs();
         probeAddr <= i < 12 ? edges[i] : wide[19:0];
         @(posedge clk_sys);
      end
      @(negedge clk_sys);
      chk("mainOscSel", 32'h0, {31'h0, mainOscSel});
      $display("decode and oscillator done");
      @(posedge clk_sys);
      srst <= 1'b1;
      idle(2);
      srst <= 1'b0;
      rdReg(IDX_DATA0, 32'h0);
      rdReg(IDX_FLAGS, 32'h0);
      idle(2);
      $display("second reset done");
      wrap_up();
   end

   initial
   begin
      repeat (4000) @(posedge clk_sys);
      err_total++;
      wrap_up();
   end
endmodule : tb

bind cpurs_register_set cpurs_assertions u_cpurs_assertions
(
   .clk_sys(clk_sys),
   .srst(srst),
   .bus(bus),
   .probeAddr(probeAddr),
   .probeDecode(probeDecode),
   .oscSelect(oscSelect),
   .mainOscSel(mainOscSel),
   .bankSel(bankSel)
);
`default_nettype wire
